// ===== hw/vdl_link.sv
`timescale 1ns/10ps
// Function
// R1 - finished shift byte reloads from transmit shadow
// R2 - tx empty once first bit sent
// R3 - host writes bytes only after tx empty
// R4 - complete byte copied to rx shadow, full
// R5 - data read returns latest received byte
// R6 - unread rx shadow overwritten by next byte
// R7 - starved transmitter underruns after two ones
// R8 - cut-short frame reported as invalid symbol
// R9 - wait entry when wait-clock bit clear; no drive
// R10 - received message wakes wait, irq if enabled
// R11 - clocks kept running in wait mode
// R12 - stop on stop, or wait with bit set
// R13 - stop: bus activity wakes, non-maskable request
// R14 - stop-instruction wake message may be lost
// R15 - wait-entered stop receives only after eof
// R16 - host finishes transmissions before wait
// R17 - data address: writes tx shadow, reads rx
module vdl_link
	import vdl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire vdl_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_wait_i,
	input wire logic cpu_stop_i,
	input wire logic cpu_run_i,
	input wire logic bus_rx_i,
	output logic bus_tx_o,
	output logic irq_o,
	output logic nmi_o,
	output logic clk_stop_o
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [2:0] ctrl_ff;
	logic [5:0] status_ff;
	logic [5:0] mask_ff;
	logic [7:0] tx_shadow_ff;
	logic tx_full_ff;
	logic [7:0] rx_shadow_ff;
	vdl_pwr_t pwr_ff;
	logic stop_by_wait_ff;
	logic eof_seen_ff;
	logic rx_lvl;
	logic [5:0] set_ev;
	logic [5:0] clr_w;
	logic [3:0] vector;
	logic wr;
	logic rd_data;
	logic acc;

	assign acc = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
	assign wr = acc & wb_req_i.we & wb_req_i.sel[0];
	assign rd_data = acc & ~wb_req_i.we & (wb_req_i.adr == ADDR_DATA);

	vdl_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(bus_rx_i),
		.level_o(rx_lvl)
	);

	// ----------------------------------------------------------------
	// bus slave: one wait state, ack for one cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= acc;
			if (acc) begin
				if (wb_req_i.adr == ADDR_DATA) begin
					wb_dat_o <= {24'h0, rx_shadow_ff}; // R5 R17
				end else if (wb_req_i.adr == ADDR_CTRL) begin
					wb_dat_o <= {29'h0, ctrl_ff};
				end else if (wb_req_i.adr == ADDR_STATUS) begin
					wb_dat_o <= {26'h0, status_ff};
				end else if (wb_req_i.adr == ADDR_IRQ_MASK) begin
					wb_dat_o <= {26'h0, mask_ff};
				end else if (wb_req_i.adr == ADDR_VECTOR) begin
					wb_dat_o <= {28'h0, vector};
				end else begin
					wb_dat_o <= 32'h0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= CTRL_RESET;
			mask_ff <= MASK_RESET;
		end else if (wr && wb_req_i.adr == ADDR_CTRL) begin
			ctrl_ff <= wb_req_i.dat[2:0];
		end else if (wr && wb_req_i.adr == ADDR_IRQ_MASK) begin
			mask_ff <= wb_req_i.dat[5:0];
		end
	end

	// ----------------------------------------------------------------
	// power modes
	// ----------------------------------------------------------------
	logic rx_prev_ff;
	logic rx_rise;
	logic rx_msg_done;
	assign rx_rise = rx_lvl & ~rx_prev_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_ff <= PWR_RUN;
			stop_by_wait_ff <= 1'b0;
			nmi_o <= 1'b0;
		end else begin
			nmi_o <= 1'b0;
			case (pwr_ff)
				PWR_RUN: begin
					if (cpu_stop_i) begin
						pwr_ff <= PWR_STOP; // R12
						stop_by_wait_ff <= 1'b0;
					end else if (cpu_wait_i && ctrl_ff[CTRL_WAIT_CLK]) begin
						pwr_ff <= PWR_STOP; // R12
						stop_by_wait_ff <= 1'b1;
					end else if (cpu_wait_i) begin
						pwr_ff <= PWR_WAIT; // R9
					end
				end
				PWR_WAIT: begin
					// clocks stay on here so the waking frame is intact
					if (rx_msg_done || cpu_run_i) begin // R10 R11
						pwr_ff <= PWR_RUN;
					end
				end
				PWR_STOP: begin
					if (rx_rise) begin
						pwr_ff <= PWR_RUN; // R13
						nmi_o <= 1'b1; // R13
					end
				end
				default: pwr_ff <= PWR_RUN;
			endcase
		end
	end
	// stop gates the module clock outside; the edge detector and its synchronizer still run on clk_i then
	assign clk_stop_o = (pwr_ff == PWR_STOP);

	// ----------------------------------------------------------------
	// receiver: pulse widths decode into bits
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] rx_cnt_ff;
	logic [7:0] rx_shift_ff;
	logic [2:0] rx_bits_ff;
	logic rx_in_frame_ff;
	logic rx_bad_ff;
	logic rx_edge;
	logic rx_bit;
	logic [CNT_W-1:0] thr;
	assign thr = CNT_W'(SHORT_CYC + SHORT_CYC / 2);
	assign rx_edge = rx_lvl ^ rx_prev_ff;
	// active short or passive long is a one
	assign rx_bit = rx_prev_ff ? (rx_cnt_ff < thr) : (rx_cnt_ff >= thr);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_prev_ff <= 1'b0;
			rx_cnt_ff <= CNT_RESET;
			rx_shift_ff <= 8'h00;
			rx_bits_ff <= 3'h0;
			rx_in_frame_ff <= 1'b0;
			rx_bad_ff <= 1'b0;
			eof_seen_ff <= 1'b1;
			rx_msg_done <= 1'b0;
		end else begin
			rx_prev_ff <= rx_lvl;
			rx_msg_done <= 1'b0;
			// one-cycle event, so a w1c of the invalid flag sticks
			rx_bad_ff <= 1'b0;
			if (rx_edge) begin
				rx_cnt_ff <= CNT_RESET;
				if (!rx_in_frame_ff && rx_lvl) begin
					// stop via wait only keeps sync if eof came first
					if (!(pwr_ff == PWR_STOP && !(stop_by_wait_ff && eof_seen_ff))) begin // R14 R15
						rx_in_frame_ff <= 1'b1;
					end
					eof_seen_ff <= 1'b0;
					rx_bits_ff <= 3'h0;
				end else if (rx_in_frame_ff && !(rx_prev_ff && rx_cnt_ff >= CNT_W'(LONG_CYC))) begin
					rx_shift_ff <= {rx_shift_ff[6:0], rx_bit};
					rx_bits_ff <= rx_bits_ff + 3'h1;
				end
			end else if (rx_cnt_ff != 16'hffff) begin
				rx_cnt_ff <= rx_cnt_ff + 16'h0001;
			end
			if (!rx_lvl && rx_cnt_ff == CNT_W'(EOF_CYC) && !eof_seen_ff) begin
				eof_seen_ff <= 1'b1;
				rx_in_frame_ff <= 1'b0;
				// frame ending mid byte is the byte-boundary fault
				if (rx_bits_ff != 3'h0) begin
					rx_bad_ff <= 1'b1; // R8
				end else if (rx_in_frame_ff) begin
					rx_msg_done <= 1'b1; // R10
				end
			end
		end
	end

	logic rx_byte_done;
	assign rx_byte_done = rx_edge && rx_in_frame_ff && rx_bits_ff == 3'h7 && !rx_lvl;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_shadow_ff <= 8'h00;
		end else if (rx_byte_done) begin
			// an unread byte is simply overwritten
			rx_shadow_ff <= {rx_shift_ff[6:0], rx_bit}; // R4 R6
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	vdl_tx_t tx_st_ff;
	logic [7:0] tx_shift_ff;
	logic [3:0] tx_bits_ff;
	logic [CNT_W-1:0] tx_cnt_ff;
	logic tx_lvl_ff;
	logic tx_cur;
	logic tx_load;
	logic tx_underrun;
	logic [CNT_W-1:0] tx_len;
	assign tx_cur = (tx_st_ff == TX_TAIL) ? 1'b1 : tx_shift_ff[7];
	// next symbol, level after the toggle: active short or passive long is a one
	assign tx_len = CNT_W'((tx_cur ^ ~tx_lvl_ff) ? LONG_CYC : SHORT_CYC);
	assign tx_load = (tx_st_ff == TX_DATA) && tx_cnt_ff == 16'h0001 && tx_bits_ff == 4'h7;
	assign tx_underrun = tx_load && !tx_full_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_ff <= TX_IDLE;
			tx_shift_ff <= 8'h00;
			tx_bits_ff <= 4'h0;
			tx_cnt_ff <= CNT_RESET;
			tx_lvl_ff <= 1'b0;
		end else begin
			if (tx_cnt_ff != CNT_RESET) begin
				tx_cnt_ff <= tx_cnt_ff - 16'h0001;
			end
			case (tx_st_ff)
				TX_IDLE: begin
					tx_lvl_ff <= 1'b0;
					if (tx_full_ff && ctrl_ff[CTRL_TX_EN] && pwr_ff == PWR_RUN && !rx_lvl) begin
						tx_st_ff <= TX_SOF;
						tx_lvl_ff <= 1'b1;
						tx_cnt_ff <= CNT_W'(3 * SHORT_CYC);
						tx_shift_ff <= tx_shadow_ff;
					end
				end
				TX_SOF: begin
					if (tx_cnt_ff == 16'h0001) begin
						tx_st_ff <= TX_DATA;
						tx_lvl_ff <= 1'b0;
						tx_bits_ff <= 4'h0;
						tx_cnt_ff <= CNT_W'(tx_shift_ff[7] ? LONG_CYC : SHORT_CYC);
					end
				end
				TX_DATA: begin
					if (tx_cnt_ff == 16'h0001) begin
						tx_lvl_ff <= ~tx_lvl_ff;
						if (tx_bits_ff == 4'h7 && tx_full_ff) begin
							tx_shift_ff <= tx_shadow_ff; // R1
							tx_bits_ff <= 4'h0;
							tx_cnt_ff <= CNT_W'((tx_shadow_ff[7] ^ ~tx_lvl_ff) ? LONG_CYC
								: SHORT_CYC);
						end else if (tx_bits_ff == 4'h7) begin
							tx_st_ff <= TX_TAIL; // R7
							tx_bits_ff <= 4'h0;
							tx_cnt_ff <= CNT_W'(~tx_lvl_ff ? SHORT_CYC : LONG_CYC);
						end else begin
							tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
							tx_bits_ff <= tx_bits_ff + 4'h1;
							tx_cnt_ff <= CNT_W'((tx_shift_ff[6] ^ ~tx_lvl_ff) ? LONG_CYC
								: SHORT_CYC);
						end
					end
				end
				TX_TAIL: begin
					// two ones past the byte force a boundary fault downstream
					if (tx_cnt_ff == 16'h0001) begin
						tx_lvl_ff <= ~tx_lvl_ff;
						tx_cnt_ff <= tx_len;
						tx_bits_ff <= tx_bits_ff + 4'h1;
						if (tx_bits_ff == 4'h1) begin
							tx_st_ff <= TX_IDLE; // R7
							tx_lvl_ff <= 1'b0;
						end
					end
				end
				default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	// shadow frees once the first bit of the loaded byte is out
	logic tx_first_bit;
	assign tx_first_bit = (tx_st_ff == TX_DATA) && tx_cnt_ff == 16'h0001 && tx_bits_ff == 4'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_shadow_ff <= 8'h00;
			tx_full_ff <= 1'b0;
		end else if (wr && wb_req_i.adr == ADDR_DATA) begin
			tx_shadow_ff <= wb_req_i.dat[7:0]; // R17 R3
			tx_full_ff <= 1'b1;
		end else if (tx_first_bit) begin
			tx_full_ff <= 1'b0; // R2
		end
	end

	// never drive in wait or stop
	assign bus_tx_o = tx_lvl_ff & (pwr_ff == PWR_RUN); // R9 R16

	// ----------------------------------------------------------------
	// sticky status, mask, interrupt
	// ----------------------------------------------------------------
	always_comb begin
		set_ev = 6'h00;
		set_ev[ST_TX_EMPTY] = tx_first_bit; // R2
		set_ev[ST_RX_FULL] = rx_byte_done; // R4
		set_ev[ST_UNDERRUN] = tx_underrun; // R7
		set_ev[ST_INVALID] = rx_edge && rx_in_frame_ff && rx_lvl && rx_bits_ff != 3'h0
			&& rx_prev_ff == 1'b0 && rx_cnt_ff >= CNT_W'(LONG_CYC) || rx_bad_ff; // R8
		set_ev[ST_RX_DONE] = rx_msg_done;
		set_ev[ST_WAKE] = rx_msg_done && pwr_ff == PWR_WAIT; // R10
		clr_w = (wr && wb_req_i.adr == ADDR_STATUS) ? wb_req_i.dat[5:0] : 6'h00;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_ff <= 6'h00;
		end else begin
			// data read also clears the full flag; a new byte wins
			status_ff <= (status_ff & ~clr_w & ~(rd_data ? 6'h02 : 6'h00)) | set_ev; // R6
		end
	end

	always_comb begin
		if (status_ff[ST_INVALID]) begin
			vector = VEC_INVALID;
		end else if (status_ff[ST_RX_FULL]) begin
			vector = VEC_RX_FULL;
		end else if (status_ff[ST_TX_EMPTY]) begin
			vector = VEC_TX_EMPTY;
		end else begin
			vector = VEC_NONE;
		end
	end

	assign irq_o = ctrl_ff[CTRL_IRQ_EN] && |(status_ff & mask_ff); // R10
endmodule : vdl_link

// ===== hw/vdl_pkg.sv
package vdl_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, word aligned)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_VECTOR = 8'h10;

	// ----------------------------------------------------------------
	// control bit positions
	// ----------------------------------------------------------------
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_IRQ_EN = 1;
	localparam int CTRL_WAIT_CLK = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ----------------------------------------------------------------
	// status / mask bit positions
	// ----------------------------------------------------------------
	localparam int ST_TX_EMPTY = 0;
	localparam int ST_RX_FULL = 1;
	localparam int ST_UNDERRUN = 2;
	localparam int ST_INVALID = 3;
	localparam int ST_RX_DONE = 4;
	localparam int ST_WAKE = 5;
	localparam int ST_W = 6;
	localparam logic [5:0] MASK_RESET = 6'h00;

	// ----------------------------------------------------------------
	// timing: nominal short pulse 64 us at 100 MHz
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_SHORT_US = 64;
	localparam int SHORT_CYC = T_SHORT_US * CLK_MHZ;
	localparam int LONG_CYC = 2 * SHORT_CYC;
	localparam int EOF_CYC = 4 * SHORT_CYC;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

	// state vector codes
	localparam logic [3:0] VEC_NONE = 4'h0;
	localparam logic [3:0] VEC_RX_FULL = 4'h1;
	localparam logic [3:0] VEC_TX_EMPTY = 4'h2;
	localparam logic [3:0] VEC_INVALID = 4'h3;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_WAIT = 2'b01,
		PWR_STOP = 2'b11
	} vdl_pwr_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SOF = 2'b01,
		TX_DATA = 2'b11,
		TX_TAIL = 2'b10
	} vdl_tx_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} vdl_wb_req_t;

endpackage : vdl_pkg

// ===== hw/vdl_sync.sv
`timescale 1ns/10ps
module vdl_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// pin is passive (low) at reset; change accepted once stages 2 and 3 agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_o <= s3_ff;
			end
		end
	end
endmodule : vdl_sync

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb
	import vdl_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	vdl_wb_req_t wb_req_i = '0;
	logic [2:0] cpu_req = 3'h0;
	logic node_drive = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, bus_rx, bus_tx_o, irq_o, nmi_o, clk_stop_o;
	int n_mismatch = 0;
	int checked = 0;
	int n;

	vdl_link i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cpu_wait_i(cpu_req[0]), .cpu_stop_i(cpu_req[1]),
		.cpu_run_i(cpu_req[2]), .bus_rx_i(bus_rx), .bus_tx_o(bus_tx_o), .irq_o(irq_o),
		.nmi_o(nmi_o), .clk_stop_o(clk_stop_o));
	vdl_bus_node i_node (.node_drive_i(node_drive), .dut_tx_i(bus_tx_o), .bus_o(bus_rx));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ------------
	// tasks
	// ------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus_op(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		k = 0;
		wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		wb_req_i <= '0;
		@(posedge clk_i);
		if (k >= 50) begin
			n_mismatch++;
			test_done();
		end
	endtask : bus_op

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] v;
		bus_op(1'b1, adr, d, v);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] v;
		bus_op(1'b0, adr, 32'h0, v);
		chk(v, exp);
	endtask : rd_chk

	// sel 0 waits on bus drive, 1 on irq, 2 on wake request
	task automatic wait_hi(input int sel, input int lim, output int k);
		logic v;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			v = (sel == 0) ? bus_tx_o : (sel == 1) ? irq_o : nmi_o;
		end while (v !== 1'b1 && k < lim);
		if (v !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
			test_done();
		end
	endtask : wait_hi

	task automatic pulse(input logic [2:0] p);
		cpu_req <= p;
		@(posedge clk_i);
		cpu_req <= 3'h0;
		repeat (4) @(posedge clk_i);
	endtask : pulse

	task automatic reset_dut();
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : reset_dut

	// ------------
	// sequence
	// ------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_IRQ_MASK, 32'h0);
		wr(8'h20, 32'hff);
		rd_chk(8'h20, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h3f);
		rd_chk(ADDR_IRQ_MASK, 32'h3f);
		$display("test registers done");
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_DATA, 32'h55);
		wr(ADDR_STATUS, 32'h3f);
		wr(ADDR_CTRL, 32'h3);
		wait_hi(0, 100, n);
		wait_hi(1, 5 * SHORT_CYC, n);
		chk({31'h0, n >= 4 * SHORT_CYC - 50}, 32'h1);
		rd_chk(ADDR_VECTOR, {28'h0, VEC_TX_EMPTY});
		wr(ADDR_IRQ_MASK, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(ADDR_STATUS, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_DATA, 32'h55);
		// own frame loops back: the first byte lands in the rx shadow
		wr(ADDR_IRQ_MASK, 32'h2);
		wait_hi(1, 8 * SHORT_CYC, n);
		rd_chk(ADDR_STATUS, 32'h2);
		rd_chk(ADDR_VECTOR, {28'h0, VEC_RX_FULL});
		rd_chk(ADDR_DATA, 32'h55);
		rd_chk(ADDR_STATUS, 32'h0);
		// abort the frame by reset: an underrun would cost a whole byte time
		reset_dut();
		chk({31'h0, bus_tx_o}, 32'h0);
		$display("test transmit done");
		pulse(3'h1);
		wr(ADDR_DATA, 32'ha5);
		wr(ADDR_CTRL, 32'h1);
		repeat (50) @(posedge clk_i);
		chk({30'h0, clk_stop_o, bus_tx_o}, 32'h0);
		pulse(3'h4);
		wait_hi(0, 100, n);
		reset_dut();
		$display("test wait done");
		pulse(3'h2);
		chk({31'h0, clk_stop_o}, 32'h1);
		node_drive <= 1'b1;
		wait_hi(2, 20, n);
		@(posedge clk_i);
		chk({31'h0, clk_stop_o}, 32'h0);
		node_drive <= 1'b0;
		repeat (10) @(posedge clk_i);
		wr(ADDR_CTRL, 32'h4);
		pulse(3'h1);
		chk({31'h0, clk_stop_o}, 32'h1);
		node_drive <= 1'b1;
		wait_hi(2, 20, n);
		node_drive <= 1'b0;
		$display("test stop done");
		test_done();
	end
endmodule : tb

// ===== testbench/vdl_bus_node.sv
`timescale 1ns/10ps
// ------------
// other node
// ------------
module vdl_bus_node (
	input wire logic node_drive_i,
	input wire logic dut_tx_i,
	output logic bus_o
);
	// wired bus, falls back to passive when nobody drives
	assign bus_o = node_drive_i | dut_tx_i;
endmodule : vdl_bus_node

// ===== testbench/vdl_link_assertions.sv
`timescale 1ns/10ps
module vdl_link_chk
	import vdl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire vdl_wb_req_t wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic cpu_wait_i,
	input wire logic cpu_stop_i,
	input wire logic cpu_run_i,
	input wire logic bus_rx_i,
	input wire logic bus_tx_o,
	input wire logic irq_o,
	input wire logic nmi_o,
	input wire logic clk_stop_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------------
	// properties
	// ------------
	ack_after_req_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !nmi_o && !irq_o
		&& !clk_stop_o && !bus_tx_o) else $error("output active after reset");
	wait_no_drive_a: assert property (cpu_wait_i |=> !bus_tx_o [*4])
		else $error("bus driven in wait");
	stop_entry_a: assert property (cpu_stop_i && !clk_stop_o |=> clk_stop_o)
		else $error("stop not entered");
	nmi_wake_a: assert property (clk_stop_o && $rose(bus_rx_i) |-> ##[1:6] nmi_o)
		else $error("no wake request");
	nmi_cause_a: assert property (nmi_o |-> $past(clk_stop_o) || $past(clk_stop_o, 2))
		else $error("wake request outside stop");
	nmi_pulse_a: assert property (nmi_o |=> !nmi_o) else $error("wake request too long");
	ack_c: cover property (wb_ack_o && !wb_req_i.we);
	irq_c: cover property ($rose(irq_o));
	wake_c: cover property ($fell(clk_stop_o));
endmodule : vdl_link_chk

bind vdl_link vdl_link_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_wait_i(cpu_wait_i), .cpu_stop_i(cpu_stop_i),
	.cpu_run_i(cpu_run_i), .bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o), .irq_o(irq_o),
	.nmi_o(nmi_o), .clk_stop_o(clk_stop_o));
